// ### core/dbsps_regs.vh
/*
  Register offsets, field positions, operation codes and reset values for the
  accumulator, product and bit-set execution block.
  Assumes it is included by bare name from the design files.
*/
`ifndef DBSPS_REGS_VH
`define DBSPS_REGS_VH

// Word indices on the register bus; the byte address is four times the index.
`define DBSPS_OFF_CMD 6'h00
`define DBSPS_OFF_ADDR 6'h01
`define DBSPS_OFF_ACC 6'h02
`define DBSPS_OFF_PROD 6'h03
`define DBSPS_OFF_ST0 6'h04
`define DBSPS_OFF_ST1 6'h05
`define DBSPS_OFF_STAT 6'h06
`define DBSPS_OFF_LOADVAL 6'h07
`define DBSPS_OFF_WAITS 6'h08
`define DBSPS_OFF_MEMRD 6'h09

// Command word fields.
`define DBSPS_CMD_OP_LSB 0
`define DBSPS_CMD_BIT_LSB 3
`define DBSPS_CMD_PEXT_BIT 6
`define DBSPS_CMD_LOC_LSB 8
`define DBSPS_CMD_SAME_BIT 10
`define DBSPS_CMD_CNT_LSB 11

// Operation codes.
`define DBSPS_OP_SET_CONTROL_BIT_OP 3'h0
`define DBSPS_OP_SFL 3'h1
`define DBSPS_OP_SFR 3'h2
`define DBSPS_OP_SUBTRACT_PRODUCT_OP 3'h3
`define DBSPS_OP_SPH 3'h4
`define DBSPS_OP_SPL 3'h5
`define DBSPS_OP_LST0 3'h6
`define DBSPS_OP_LST1 3'h7

// Operand placement codes.
`define DBSPS_LOC_DUAL 2'h0
`define DBSPS_LOC_SINGLE 2'h1
`define DBSPS_LOC_EXT 2'h2

// Status bit positions.
`define DBSPS_ST0_OV 12
`define DBSPS_ST0_OVM 11
`define DBSPS_ST0_INTERRUPT_MASK_MODE 9
`define DBSPS_ST1_CNF 12
`define DBSPS_ST1_TC 11
`define DBSPS_ST1_SXM 10
`define DBSPS_ST1_C 9
`define DBSPS_ST1_XF 4

// Product shift mode codes.
`define DBSPS_PM_NONE 2'h0
`define DBSPS_PM_L1 2'h1
`define DBSPS_PM_L4 2'h2
`define DBSPS_PM_R6 2'h3

// Reset values.
`define DBSPS_ST0_RST 16'h0000
`define DBSPS_ST1_RST 16'h0000
`define DBSPS_WAITS_RST 8'h00

// Bus response codes.
`define DBSPS_RESP_OKAY 2'h0
`define DBSPS_RESP_SLVERR 2'h2

`endif

// ### core/dbsps_prod_shifter.v
/*
  Product shifter: scales the 32-bit product value by the selected mode.
  Assumes the product value and mode are registered in the caller's clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dbsps_regs.vh"

module dbsps_prod_shifter (
  input wire [31:0] prodIn,
  input wire [1:0] shiftMode,
  output reg [31:0] prodOut
);

  // Pure combinational shift of a full copy of the product value.
  always @*
  begin
    case (shiftMode)
      `DBSPS_PM_NONE: prodOut = prodIn;
      `DBSPS_PM_L1: prodOut = {prodIn[30:0], 1'b0};
      `DBSPS_PM_L4: prodOut = {prodIn[27:0], 4'h0};
      `DBSPS_PM_R6: prodOut = {{6{prodIn[31]}}, prodIn[31:6]};
      default: prodOut = prodIn;
    endcase
  end

endmodule
`default_nettype wire

// ### core/dbsps_data_mem.v
/*
  Small 16-bit data memory that receives product stores.
  Assumes one clock; read data come out of a register one cycle after the address.
*/
`timescale 1ns/100ps
`default_nettype none

module dbsps_data_mem #(
  parameter AW = 8
) (
  input wire clock,
  input wire rstn,
  input wire writeEn,
  input wire [AW-1:0] writeAddr,
  input wire [15:0] writeData,
  input wire [AW-1:0] readAddr,
  output reg [15:0] readData_reg
);

  reg [15:0] words [0:(1<<AW)-1];

  // Write port; contents are not reset.
  always @(posedge clock)
  begin
    if (writeEn)
      words[writeAddr] <= writeData;
  end

  // Registered read port.
  always @(posedge clock)
  begin
    if (!rstn)
      readData_reg <= 16'h0000;
    else
      readData_reg <= words[readAddr];
  end

endmodule
`default_nettype wire

// ### core/dbsps_core.v
/*
  Execution block for bit-set, accumulator shift, product subtract and product
  store operations, with an AXI4-Lite register slave.
  Assumes a single clock and a synchronous active-low reset; the store target is
  the internal data memory instance.
*/
// Added by the designer: the register offsets and the AXI4-Lite register port.
// How it works
// - Set-bit forces chosen flag, others unchanged.
// - Flags live in two status words, loadable.
// - Single set-bit costs one, plus program waits.
// - Repeated set-bit costs n plus program waits.
// - Left shift: bit 31 to carry, zero in.
// - Low store writes low shifted product half.
// - Stores use full product through current shifter.
// - Right-six mode sign-extends, drops low bits.
// - Left modes drop top bits, zero fill.
// - Mode zero passes product unshifted.
// - Stores leave product and accumulator alone.
// - Single high store cost by placement.
// - Repeated high store: n, or 2n+nd.
// - Same single-access block adds one or two.
// - Shift mode sits in bits 1:0 of word 1.
`timescale 1ns/100ps
`default_nettype none
`include "dbsps_regs.vh"

module dbsps_core #(
  parameter MEM_AW = 8
) (
  input wire clock,
  input wire rstn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  reg [7:0] awAddr_reg;
  reg awHeld_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg wHeld_reg;
  reg [7:0] arAddr_reg;
  reg rdPend_reg;
  reg [31:0] acc_reg, acc_next;
  reg [31:0] prod_reg, prod_next;
  reg [15:0] st0_reg, st0_next;
  reg [15:0] st1_reg, st1_next;
  reg [MEM_AW-1:0] addr_reg;
  reg [15:0] loadVal_reg;
  reg [7:0] waits_reg;
  reg [2:0] op_reg;
  reg [2:0] bitSel_reg;
  reg [7:0] iters_reg;
  reg [15:0] cycles_reg;
  reg memWe;
  reg [15:0] memWdata;
  reg [32:0] diff;
  reg ovf;
  wire [31:0] shiftedProd;
  wire [15:0] memRd;
  wire busy;
  wire doWrite;
  wire [5:0] wIdx;
  wire [31:0] wMask;

  // Busy flag, write decode and the byte mask of the captured strobes.
  assign busy = (cycles_reg != 16'h0000);
  assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign wIdx = awAddr_reg[7:2];
  assign wMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}}, {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
  assign s_axi_arready = !rdPend_reg && !s_axi_rvalid;

  // Total cycles an operation occupies, from program and operand placement.
  function [15:0] cycleCost;
    input [2:0] op;
    input progExt;
    input [1:0] loc;
    input sameBlock;
    input [7:0] cnt;
    input [3:0] pw;
    input [3:0] dw;
    reg [15:0] n, p, d;
    reg rep;
    begin
      n = (cnt == 8'h00) ? 16'h0001 : {8'h00, cnt};
      p = progExt ? {12'h000, pw} : 16'h0000;
      d = {12'h000, dw};
      rep = (cnt != 8'h00);
      if (op != `DBSPS_OP_SPH && op != `DBSPS_OP_SPL)
        cycleCost = n + p;
      else if (loc == `DBSPS_LOC_EXT)
      begin
        if (rep)
          cycleCost = n + n + n * d + (progExt ? 16'h0002 + p : 16'h0000);
        else
          cycleCost = progExt ? 16'h0004 + d + p : 16'h0002 + d;
      end
      else if (loc == `DBSPS_LOC_SINGLE && sameBlock && !progExt)
        cycleCost = n + (rep ? 16'h0002 : 16'h0001);
      else
        cycleCost = n + p;
    end
  endfunction

  // Full product copy goes through the shifter before any use.
  dbsps_prod_shifter uShifter (
    .prodIn(prod_reg),
    .shiftMode(st1_reg[1:0]),
    .prodOut(shiftedProd)
  );
  // Store target; its registered read feeds the memory readback word.
  dbsps_data_mem #(.AW(MEM_AW)) uMem (
    .clock(clock), .rstn(rstn), .writeEn(memWe), .writeAddr(addr_reg),
    .writeData(memWdata), .readAddr(addr_reg), .readData_reg(memRd)
  );

  // Datapath: one repetition of the latched operation per cycle, or a bus write.
  always @*
  begin
    acc_next = acc_reg;
    prod_next = prod_reg;
    st0_next = st0_reg;
    st1_next = st1_reg;
    memWe = 1'b0;
    memWdata = 16'h0000;
    diff = {1'b0, acc_reg} - {1'b0, shiftedProd};
    ovf = (acc_reg[31] != shiftedProd[31]) && (diff[31] != acc_reg[31]);
    if (iters_reg != 8'h00)
    begin
      case (op_reg)
        `DBSPS_OP_SET_CONTROL_BIT_OP:
        begin
          case (bitSel_reg)
            3'h0: st1_next[`DBSPS_ST1_C] = 1'b1;
            3'h1: st1_next[`DBSPS_ST1_CNF] = 1'b1;
            3'h2: st0_next[`DBSPS_ST0_INTERRUPT_MASK_MODE] = 1'b1;
            3'h3: st0_next[`DBSPS_ST0_OVM] = 1'b1;
            3'h4: st1_next[`DBSPS_ST1_SXM] = 1'b1;
            3'h5: st1_next[`DBSPS_ST1_TC] = 1'b1;
            3'h6: st1_next[`DBSPS_ST1_XF] = 1'b1;
            default: st1_next = st1_reg;
          endcase
        end
        `DBSPS_OP_SFL:
        begin
          st1_next[`DBSPS_ST1_C] = acc_reg[31];
          acc_next = {acc_reg[30:0], 1'b0};
        end
        `DBSPS_OP_SFR:
        begin
          st1_next[`DBSPS_ST1_C] = acc_reg[0];
          acc_next = {st1_reg[`DBSPS_ST1_SXM] & acc_reg[31], acc_reg[31:1]};
        end
        `DBSPS_OP_SUBTRACT_PRODUCT_OP:
        begin
          st1_next[`DBSPS_ST1_C] = !diff[32];
          st0_next[`DBSPS_ST0_OV] = st0_reg[`DBSPS_ST0_OV] | ovf;
          if (ovf && st0_reg[`DBSPS_ST0_OVM])
            acc_next = acc_reg[31] ? 32'h80000000 : 32'h7FFFFFFF;
          else
            acc_next = diff[31:0];
        end
        `DBSPS_OP_SPH:
        begin
          memWe = 1'b1;
          memWdata = shiftedProd[31:16];
        end
        `DBSPS_OP_SPL:
        begin
          memWe = 1'b1;
          memWdata = shiftedProd[15:0];
        end
        `DBSPS_OP_LST0: st0_next = loadVal_reg;
        `DBSPS_OP_LST1: st1_next = loadVal_reg;
        default: acc_next = acc_reg;
      endcase
    end
    else if (doWrite && !busy)
    begin
      if (wIdx == `DBSPS_OFF_ACC)
        acc_next = (acc_reg & ~wMask) | (wData_reg & wMask);
      if (wIdx == `DBSPS_OFF_PROD)
        prod_next = (prod_reg & ~wMask) | (wData_reg & wMask);
    end
  end

  // Architectural state and operation sequencing.
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      acc_reg <= 32'h00000000;
      prod_reg <= 32'h00000000;
      st0_reg <= `DBSPS_ST0_RST;
      st1_reg <= `DBSPS_ST1_RST;
      addr_reg <= {MEM_AW{1'b0}};
      loadVal_reg <= 16'h0000;
      waits_reg <= `DBSPS_WAITS_RST;
      op_reg <= `DBSPS_OP_SET_CONTROL_BIT_OP;
      bitSel_reg <= 3'h0;
      iters_reg <= 8'h00;
      cycles_reg <= 16'h0000;
    end
    else
    begin
      acc_reg <= acc_next;
      prod_reg <= prod_next;
      st0_reg <= st0_next;
      st1_reg <= st1_next;
      if (iters_reg != 8'h00)
        iters_reg <= iters_reg - 8'h01;
      if (busy)
        cycles_reg <= cycles_reg - 16'h0001;
      if (doWrite && !busy)
      begin
        if (wIdx == `DBSPS_OFF_ADDR)
          addr_reg <= wData_reg[MEM_AW-1:0];
        if (wIdx == `DBSPS_OFF_LOADVAL)
          loadVal_reg <= (loadVal_reg & ~wMask[15:0]) | (wData_reg[15:0] & wMask[15:0]);
        if (wIdx == `DBSPS_OFF_WAITS && wStrb_reg[0])
          waits_reg <= wData_reg[7:0];
        if (wIdx == `DBSPS_OFF_CMD)
        begin
          op_reg <= wData_reg[`DBSPS_CMD_OP_LSB +: 3];
          bitSel_reg <= wData_reg[`DBSPS_CMD_BIT_LSB +: 3];
          iters_reg <= (wData_reg[`DBSPS_CMD_CNT_LSB +: 8] == 8'h00) ? 8'h01 :
            wData_reg[`DBSPS_CMD_CNT_LSB +: 8];
          cycles_reg <= cycleCost(wData_reg[`DBSPS_CMD_OP_LSB +: 3],
            wData_reg[`DBSPS_CMD_PEXT_BIT], wData_reg[`DBSPS_CMD_LOC_LSB +: 2],
            wData_reg[`DBSPS_CMD_SAME_BIT], wData_reg[`DBSPS_CMD_CNT_LSB +: 8],
            waits_reg[3:0], waits_reg[7:4]);
        end
      end
    end
  end

  // Write channel capture and response.
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      awAddr_reg <= 8'h00;
      awHeld_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      wHeld_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DBSPS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_reg <= s_axi_awaddr;
        awHeld_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHeld_reg <= 1'b1;
      end
      if (doWrite)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wIdx > `DBSPS_OFF_MEMRD) ? `DBSPS_RESP_SLVERR : `DBSPS_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: address taken, data registered on the following edge.
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      arAddr_reg <= 8'h00;
      rdPend_reg <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DBSPS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        arAddr_reg <= s_axi_araddr;
        rdPend_reg <= 1'b1;
      end
      if (rdPend_reg)
      begin
        rdPend_reg <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= (arAddr_reg[7:2] > `DBSPS_OFF_MEMRD) ? `DBSPS_RESP_SLVERR : `DBSPS_RESP_OKAY;
        case (arAddr_reg[7:2])
          `DBSPS_OFF_CMD: s_axi_rdata <= {29'h00000000, op_reg};
          `DBSPS_OFF_ADDR: s_axi_rdata <= {{(32-MEM_AW){1'b0}}, addr_reg};
          `DBSPS_OFF_ACC: s_axi_rdata <= acc_reg;
          `DBSPS_OFF_PROD: s_axi_rdata <= prod_reg;
          `DBSPS_OFF_ST0: s_axi_rdata <= {16'h0000, st0_reg};
          `DBSPS_OFF_ST1: s_axi_rdata <= {16'h0000, st1_reg};
          `DBSPS_OFF_STAT: s_axi_rdata <= {cycles_reg, 15'h0000, busy};
          `DBSPS_OFF_LOADVAL: s_axi_rdata <= {16'h0000, loadVal_reg};
          `DBSPS_OFF_WAITS: s_axi_rdata <= {24'h000000, waits_reg};
          `DBSPS_OFF_MEMRD: s_axi_rdata <= {16'h0000, memRd};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### dv/dbsps_core_assertions.sv
/*
  Checker for the register bus handshakes of the execution block.
  Assumes one clock and a synchronous active-low reset on the top ports.
*/
`timescale 1ns/100ps
`default_nettype none
module dbsps_core_assertions (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] rdAddr_reg;
  logic [7:0] wrAddr_reg;
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Remembers the addresses of the read and of the write under way.
  always @(posedge clock)
  begin
    if (s_axi_arvalid && s_axi_arready)
      rdAddr_reg <= s_axi_araddr;
    if (s_axi_awvalid && s_axi_awready)
      wrAddr_reg <= s_axi_awaddr;
  end
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  write_busy_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while answering");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  read_time_a: assert property (s_axi_arvalid && s_axi_arready |=>
    !s_axi_rvalid ##[1:2] s_axi_rvalid) else $error("read answer late");
  write_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  bresp_code_a: assert property (s_axi_bvalid |->
    s_axi_bresp == ((wrAddr_reg[7:2] > 6'h09) ? 2'h2 : 2'h0))
    else $error("write response code wrong");
  unmapped_err_a: assert property (s_axi_rvalid && rdAddr_reg[7:2] > 6'h09 |->
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read wrong");
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_arvalid && s_axi_arready);
endmodule
bind dbsps_core dbsps_core_assertions chk_u (
  .clock(clock), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// ### dv/dbsps_mem_ref.sv
/*
  Reference image of the data memory that product stores fill.
  Assumes the bench puts each expected word in while it addresses it.
*/
`timescale 1ns/100ps
`default_nettype none
module dbsps_mem_ref (
  input wire logic clock,
  input wire logic put,
  input wire logic [7:0] addr,
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  logic [15:0] image [0:255];
  // One word is written per store, nothing else changes.
  always @(posedge clock)
  begin
    if (put)
      image[addr] <= din;
  end
  // The addressed word is shown at once.
  assign dout = image[addr];
endmodule
`default_nettype wire

// ### dv/dbsps_testbench.sv
/*
  Self-checking bench for the execution block, driven over its register bus.
  Assumes the design files and the data memory reference are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'h0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'h0;
  logic refPut = 1'h0;
  logic [7:0] refAddr = 8'h00;
  logic [15:0] refData = 16'h0;
  logic [15:0] refOut;
  logic [1:0] wrResp;
  int fails = 0;
  int check_count = 0;
  dbsps_core #(.MEM_AW(8)) dut_u (
    .clock(clock), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  dbsps_mem_ref ref_u (.clock(clock), .put(refPut), .addr(refAddr), .din(refData),
    .dout(refOut));
  // Clock of 100 ns period.
  always #50 clock = ~clock;
  // Write cycle: offers address and data, releases each when taken; bready stays high.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    wrResp = s_axi_bresp;
  endtask
  // Read cycle: holds the request until taken, waits for the answer.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk($sformatf("reg %h", a), e, d);
  endtask
  // Launches a command; a known cost of three or more shows cost minus two left.
  task automatic run(input logic [31:0] c, input int cost);
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h00, c);
    rd(8'h18, d, r);
    if (cost >= 3)
      chk("cycles left", ((cost - 2) << 16) | 1, d);
    while (d[0] !== 1'h0)
      rd(8'h18, d, r);
  endtask
  function automatic logic [31:0] cw(input int op, input int bt, input int px,
    input int lc, input int sm, input int n);
    cw = op | bt << 3 | px << 6 | lc << 8 | sm << 10 | n << 11;
  endfunction
  function automatic logic [31:0] psh(input logic [31:0] p, input int m);
    case (m)
      1: psh = p << 1;
      2: psh = p << 4;
      3: psh = $signed(p) >>> 6;
      default: psh = p;
    endcase
  endfunction
  task automatic ldst(input int op, input logic [31:0] v);
    wr(8'h1C, v);
    run(cw(op, 7, 0, 0, 0, 0), 0);
  endtask
  task automatic mem(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0] r;
    refAddr <= a;
    refData <= e;
    refPut <= 1'h1;
    wr(8'h04, {24'h0, a});
    refPut <= 1'h0;
    rd(8'h24, d, r);
    chk("memory word", {16'h0, refOut}, d);
  endtask
  task automatic t_setbit;
    int pos[7] = '{9, 12, 9, 11, 10, 11, 4};
    logic [15:0] e0 = 16'h0;
    logic [15:0] e1 = 16'h0;
    rc(8'h10, 32'h0);
    rc(8'h14, 32'h0);
    wr(8'h20, 32'h2C);
    for (int b = 0; b < 7; b++)
    begin
      run(cw(0, b, b > 4, 0, 0, b == 6 ? 40 : 0), b == 5 ? 13 : b == 6 ? 52 : 0);
      if (b == 2 || b == 3)
        e0[pos[b]] = 1'h1;
      else
        e1[pos[b]] = 1'h1;
      rc(8'h10, {16'h0, e0});
      rc(8'h14, {16'h0, e1});
    end
  endtask
  task automatic t_shift;
    ldst(7, 32'h0400);
    wr(8'h08, 32'hB0001234);
    run(cw(1, 7, 0, 0, 0, 0), 0);
    rc(8'h08, 32'h60002468);
    rc(8'h14, 32'h0600);
    wr(8'h08, 32'hB0001234);
    run(cw(2, 7, 0, 0, 0, 0), 0);
    rc(8'h08, 32'hD800091A);
    rc(8'h14, 32'h0400);
    ldst(7, 32'h0);
    wr(8'h08, 32'hB0001235);
    run(cw(2, 7, 0, 0, 0, 0), 0);
    rc(8'h08, 32'h5800091A);
    rc(8'h14, 32'h0200);
  endtask
  task automatic t_store;
    logic [31:0] v;
    wr(8'h0C, 32'hFE079844);
    wr(8'h08, 32'h12345678);
    for (int m = 0; m < 4; m++)
    begin
      ldst(7, m);
      wr(8'h04, 2 * m);
      run(cw(4, 7, 0, 0, 0, 0), 0);
      wr(8'h04, 2 * m + 1);
      run(cw(5, 7, 0, 0, 0, 0), 0);
      v = psh(32'hFE079844, m);
      mem(2 * m, v[31:16]);
      mem(2 * m + 1, v[15:0]);
    end
    rc(8'h0C, 32'hFE079844);
    rc(8'h08, 32'h12345678);
    wr(8'h04, 32'h9);
    run(cw(4, 7, 0, 2, 0, 20), 80);
    run(cw(5, 7, 1, 2, 0, 0), 18);
    run(cw(4, 7, 0, 1, 1, 20), 22);
    mem(8'h09, 16'hFFF8);
  endtask
  task automatic t_sub;
    ldst(7, 32'h0);
    ldst(6, 32'h0);
    wr(8'h08, 32'h10);
    wr(8'h0C, 32'h3);
    run(cw(3, 7, 0, 0, 0, 0), 0);
    rc(8'h08, 32'hD);
    rc(8'h14, 32'h0200);
    wr(8'h08, 32'h80000000);
    wr(8'h0C, 32'h1);
    run(cw(3, 7, 0, 0, 0, 0), 0);
    rc(8'h08, 32'h7FFFFFFF);
    rc(8'h10, 32'h1000);
    ldst(6, 32'h0800);
    wr(8'h08, 32'h80000000);
    run(cw(3, 7, 0, 0, 0, 0), 0);
    rc(8'h08, 32'h80000000);
    rc(8'h10, 32'h1800);
  endtask
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h10, 32'hFFFF);
    chk("write resp", 32'h0, {30'h0, wrResp});
    rc(8'h10, 32'h1800);
    wr(8'h28, 32'h0);
    chk("unmapped write resp", 32'h2, {30'h0, wrResp});
    rd(8'h28, d, r);
    chk("unmapped resp", 32'h2, {30'h0, r});
    chk("unmapped data", 32'h0, d);
  endtask
  // Mid-run reset clears the status words, accumulator and busy state.
  task automatic t_reset;
    rstn <= 1'h0;
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    rc(8'h10, 32'h0);
    rc(8'h14, 32'h0);
    rc(8'h08, 32'h0);
    rc(8'h18, 32'h0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence after five reset cycles.
  initial
  begin
    repeat (5) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    t_setbit();
    t_shift();
    t_store();
    t_sub();
    t_bus();
    t_reset();
    test_done();
  end
  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    #(100 * 20000);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
